// ### wake_filter_pkg.sv
// Shared constants for the wake-up frame identifier filter registers
`default_nettype none

package wake_filter_pkg;

   // ======================================================
   // Widths
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;
   localparam int ID_W   = 29;
   localparam int LOW_W  = 13;

   // ======================================================
   // Register offsets
   localparam logic [6:0] OFFS_CTRL      = 7'h30;
   localparam logic [6:0] OFFS_ID_HIGH   = 7'h32;
   localparam logic [6:0] OFFS_ID_LOW    = 7'h33;
   localparam logic [6:0] OFFS_MASK_HIGH = 7'h34;

   // ======================================================
   // Reset values
   localparam logic [15:0] ID_LOW_RESET    = 16'h0000;
   localparam logic [15:0] ID_HIGH_RESET   = 16'h0000;
   localparam logic [15:0] MASK_HIGH_RESET = 16'h0000;
   localparam logic        CFG_VALID_RESET = 1'b0;
   localparam logic [15:0] RDATA_RESET     = 16'h0000;

   // ======================================================
   // Field layout of the identifier low register and the control register valid bit
   localparam logic [15:0] ID_LOW_WMASK   = 16'hFF7F;
   localparam int          POS_RESERVED   = 7;
   localparam int          POS_REMOTE_REQ = 1;
   localparam int          POS_EXTENDED   = 0;
   localparam int          POS_CFG_VALID  = 0;
   localparam int          UPPER_ID_MSB   = 15;
   localparam int          UPPER_ID_LSB   = 8;
   localparam int          LOWER_ID_MSB   = 6;
   localparam int          LOWER_ID_LSB   = 2;

endpackage

`default_nettype wire

// ### wake_id_compare.sv
// Per-bit masked comparison of a received frame identifier and flags
`timescale 1ns/100ps
`default_nettype none

module wake_id_compare (
   input  wire logic [28:0] expected_id,
   input  wire logic [28:0] compare_enable,
   input  wire logic        expected_remote,
   input  wire logic        expected_extended,
   input  wire logic [28:0] rx_id,
   input  wire logic        rx_remote,
   input  wire logic        rx_extended,
   output logic             id_hit
);

   logic [28:0] bit_ok;

   // ======================================================
   // Disabled bits always agree
   genvar g;
   generate
      for (g = 0; g < wake_filter_pkg::ID_W; g++) begin : g_bit
         assign bit_ok[g] = !compare_enable[g] || (expected_id[g] == rx_id[g]);
      end
   endgenerate

   assign id_hit = (&bit_ok) && (expected_remote == rx_remote)
                   && (expected_extended == rx_extended);

endmodule

`default_nettype wire

// ### wake_frame_id_filter_regs.sv
// Wake-up frame identifier and mask registers with the identifier match
//
// Function
// - Identifier low register bits 15..8 hold identifier bits 12..5, read-write.
// - Bit 7 of the identifier low register is reserved, ignores writes and reads zero.
// - Identifier low register bits 6..2 hold identifier bits 4..0, read-write.
// - Bit 1 holds the expected remote-request flag, zero for data frame, one for remote request.
// - Bit 0 holds the expected extension flag, zero for 11 bit and one for 29 bit identifiers.
// - The high mask register holds compare enables for identifier bits 28..13 in bits 15..0.
// - A zero enable ignores that identifier bit, a one compares it against the received frame.
// - Power-on or soft reset clears both registers to zero.
// - Restart keeps every stored bit of the identifier low register, bit 7 still reading zero.
// - Restart keeps all sixteen bits of the high mask register.
// - Identifier bits 28..13 are stored in a companion identifier high register.
// - The configuration-valid flag clears on any configuration change, a wake-up or reset.
`timescale 1ns/100ps
`default_nettype none

module wake_frame_id_filter_regs (
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic        RESTART,
   input  wire logic        WAKE_EVENT,
   input  wire logic        OTHER_CONFIG_WRITE,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [6:0]  REG_ADDR,
   input  wire logic [15:0] REG_WDATA,
   output logic      [15:0] REG_RDATA,
   input  wire logic        RX_FRAME_VALID,
   input  wire logic [28:0] RX_ID,
   input  wire logic        RX_REMOTE,
   input  wire logic        RX_EXTENDED,
   input  wire logic [12:0] LOW_COMPARE_ENABLE,
   output logic             CONFIG_VALID,
   output logic             WAKE_MATCH
);

   // ======================================================
   // Storage
   logic [15:0] id_low_reg;
   logic [15:0] id_low_next;
   logic [15:0] id_high_reg;
   logic [15:0] id_high_next;
   logic [15:0] mask_high_reg;
   logic [15:0] mask_high_next;
   logic        cfg_valid_reg;
   logic        cfg_valid_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic        match_reg;
   logic        match_next;

   // ======================================================
   // Address decode
   function automatic logic hits(input logic [6:0] addr, input logic [6:0] offs);
      hits = (addr == offs);
   endfunction

   logic wr_ok;
   logic wr_id_low;
   logic wr_id_high;
   logic wr_mask_high;
   logic wr_ctrl;
   logic cfg_change;

   // Writes during restart are dropped so stored values survive it
   assign wr_ok        = REG_WR && !RESTART;
   assign wr_id_low    = wr_ok && hits(REG_ADDR, wake_filter_pkg::OFFS_ID_LOW);
   assign wr_id_high   = wr_ok && hits(REG_ADDR, wake_filter_pkg::OFFS_ID_HIGH);
   assign wr_mask_high = wr_ok && hits(REG_ADDR, wake_filter_pkg::OFFS_MASK_HIGH);
   assign wr_ctrl      = wr_ok && hits(REG_ADDR, wake_filter_pkg::OFFS_CTRL);
   assign cfg_change   = wr_id_low || wr_id_high || wr_mask_high || OTHER_CONFIG_WRITE;

   // ======================================================
   // Next values
   // Reserved bit forced low on write
   assign id_low_next    = wr_id_low ? (REG_WDATA & wake_filter_pkg::ID_LOW_WMASK)
                                     : id_low_reg;
   assign id_high_next   = wr_id_high ? REG_WDATA : id_high_reg;
   assign mask_high_next = wr_mask_high ? REG_WDATA : mask_high_reg;

   // Clear beats a software set in the same cycle: a stale set must not validate
   assign cfg_valid_next = (cfg_change || WAKE_EVENT || RESTART) ? 1'b0
                         : wr_ctrl ? REG_WDATA[wake_filter_pkg::POS_CFG_VALID]
                         : cfg_valid_reg;

   logic [15:0] read_word;
   assign read_word =
      hits(REG_ADDR, wake_filter_pkg::OFFS_ID_LOW)    ? id_low_reg :
      hits(REG_ADDR, wake_filter_pkg::OFFS_ID_HIGH)   ? id_high_reg :
      hits(REG_ADDR, wake_filter_pkg::OFFS_MASK_HIGH) ? mask_high_reg :
      hits(REG_ADDR, wake_filter_pkg::OFFS_CTRL)      ? {15'h0, cfg_valid_reg} :
      16'h0000;
   assign rdata_next = REG_RD ? read_word : rdata_reg;

   // ======================================================
   // Identifier match
   logic [28:0] expected_id;
   logic [28:0] compare_enable;
   logic        id_hit;

   assign expected_id = {id_high_reg,
                         id_low_reg[wake_filter_pkg::UPPER_ID_MSB:wake_filter_pkg::UPPER_ID_LSB],
                         id_low_reg[wake_filter_pkg::LOWER_ID_MSB:wake_filter_pkg::LOWER_ID_LSB]};
   assign compare_enable = {mask_high_reg, LOW_COMPARE_ENABLE};

   wake_id_compare u_compare (
      .expected_id       (expected_id),
      .compare_enable    (compare_enable),
      .expected_remote   (id_low_reg[wake_filter_pkg::POS_REMOTE_REQ]),
      .expected_extended (id_low_reg[wake_filter_pkg::POS_EXTENDED]),
      .rx_id             (RX_ID),
      .rx_remote         (RX_REMOTE),
      .rx_extended       (RX_EXTENDED),
      .id_hit            (id_hit)
   );

   // Matching only armed while software has validated the setup
   assign match_next = RX_FRAME_VALID && id_hit && cfg_valid_reg;

   // ======================================================
   // Registers
   // Stored setup; restart leaves it alone because its writes are dropped
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         id_low_reg    <= wake_filter_pkg::ID_LOW_RESET;
         id_high_reg   <= wake_filter_pkg::ID_HIGH_RESET;
         mask_high_reg <= wake_filter_pkg::MASK_HIGH_RESET;
      end else begin
         id_low_reg    <= id_low_next;
         id_high_reg   <= id_high_next;
         mask_high_reg <= mask_high_next;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         cfg_valid_reg <= wake_filter_pkg::CFG_VALID_RESET;
      end else begin
         cfg_valid_reg <= cfg_valid_next;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rdata_reg <= wake_filter_pkg::RDATA_RESET;
         match_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         match_reg <= match_next;
      end
   end

   assign REG_RDATA    = rdata_reg;
   assign CONFIG_VALID = cfg_valid_reg;
   assign WAKE_MATCH   = match_reg;

   // ======================================================
   // Checks
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   sequence low_write;
      REG_WR && !RESTART && (REG_ADDR == wake_filter_pkg::OFFS_ID_LOW);
   endsequence

   sequence low_read;
      REG_RD && (REG_ADDR == wake_filter_pkg::OFFS_ID_LOW);
   endsequence

   sequence mask_write;
      REG_WR && !RESTART && (REG_ADDR == wake_filter_pkg::OFFS_MASK_HIGH);
   endsequence

   chk_upper_id_store: assert property (
      low_write |=> id_low_reg[15:8] == $past(REG_WDATA[15:8]))
      else $error("identifier bits 12..5 not stored");

   chk_reserved_reads_zero: assert property (
      low_write ##1 low_read |=> REG_RDATA[7] == 1'b0)
      else $error("reserved bit read back nonzero");

   chk_lower_id_store: assert property (
      low_write |=> id_low_reg[6:2] == $past(REG_WDATA[6:2]))
      else $error("identifier bits 4..0 not stored");

   chk_flag_bits_store: assert property (
      low_write |=> id_low_reg[1:0] == $past(REG_WDATA[1:0]))
      else $error("remote or extension flag not stored");

   chk_extended_readback: assert property (
      low_write ##1 low_read |=> REG_RDATA[0] == $past(REG_WDATA[0], 2))
      else $error("extension flag read back wrong");

   chk_mask_store_read: assert property (
      mask_write ##1 (REG_RD && REG_ADDR == wake_filter_pkg::OFFS_MASK_HIGH)
      |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("mask register read back wrong");

   chk_masked_bit_ignored: assert property (
      RX_FRAME_VALID && cfg_valid_reg && (compare_enable == 29'h00000000)
      && (RX_REMOTE == id_low_reg[1]) && (RX_EXTENDED == id_low_reg[0]) |=> WAKE_MATCH)
      else $error("fully masked frame not matched");

   chk_reset_clears: assert property (
      @(posedge REF_CLK) disable iff (1'b0)
      RST |=> (id_low_reg == 16'h0000) && (mask_high_reg == 16'h0000) && !CONFIG_VALID)
      else $error("reset did not clear registers");

   chk_restart_keeps_id: assert property (
      RESTART |=> $stable(id_low_reg) && (id_low_reg[7] == 1'b0))
      else $error("identifier low register changed on restart");

   chk_restart_keeps_mask: assert property (
      RESTART [*2] |=> $stable(mask_high_reg))
      else $error("mask register changed on restart");

   chk_high_id_store: assert property (
      REG_WR && !RESTART && (REG_ADDR == wake_filter_pkg::OFFS_ID_HIGH)
      |=> id_high_reg == $past(REG_WDATA))
      else $error("identifier high register not stored");

   chk_config_change_clears: assert property (
      (low_write or mask_write or WAKE_EVENT or OTHER_CONFIG_WRITE) |=> !CONFIG_VALID)
      else $error("valid flag survived a configuration change");

   chk_match_needs_valid: assert property (
      WAKE_MATCH |-> $past(cfg_valid_reg) && $past(RX_FRAME_VALID))
      else $error("match raised without valid configuration");

   chk_match_flags_agree: assert property (
      WAKE_MATCH |-> ($past(RX_REMOTE) == $past(id_low_reg[1]))
                     && ($past(RX_EXTENDED) == $past(id_low_reg[0])))
      else $error("match raised with disagreeing flags");

   // ======================================================
   // Match checks against a reference view built apart from the instance
   logic [28:0] ref_expected;
   logic [28:0] ref_diff;

   assign ref_expected = {id_high_reg, id_low_reg[15:8], id_low_reg[6:2]};
   assign ref_diff     = (RX_ID ^ ref_expected) & {mask_high_reg, LOW_COMPARE_ENABLE};

   sequence frame_agrees;
      RX_FRAME_VALID && cfg_valid_reg && (ref_diff == 29'h0)
      && (RX_REMOTE == id_low_reg[1]) && (RX_EXTENDED == id_low_reg[0]);
   endsequence

   sequence frame_differs;
      RX_FRAME_VALID && ((ref_diff != 29'h0)
      || (RX_REMOTE != id_low_reg[1]) || (RX_EXTENDED != id_low_reg[0]));
   endsequence

   chk_agreeing_frame_hits: assert property (
      frame_agrees |=> WAKE_MATCH)
      else $error("agreeing frame not matched");

   chk_differing_frame_misses: assert property (
      frame_differs |=> !WAKE_MATCH)
      else $error("differing frame matched");

   chk_invalid_no_match: assert property (
      RX_FRAME_VALID && !cfg_valid_reg |=> !WAKE_MATCH)
      else $error("match raised while configuration not valid");

   chk_match_single_cycle: assert property (
      WAKE_MATCH && !RX_FRAME_VALID |=> !WAKE_MATCH)
      else $error("match pulse stretched");

   // ======================================================
   // Valid flag and retention checks
   sequence ctrl_set;
      REG_WR && (REG_ADDR == wake_filter_pkg::OFFS_CTRL) && REG_WDATA[0];
   endsequence

   chk_ctrl_sets_valid: assert property (
      ctrl_set ##0 !(RESTART || WAKE_EVENT || OTHER_CONFIG_WRITE) |=> CONFIG_VALID)
      else $error("valid flag not set by software");

   chk_clear_beats_set: assert property (
      ctrl_set ##0 (RESTART || WAKE_EVENT || OTHER_CONFIG_WRITE) |=> !CONFIG_VALID)
      else $error("valid flag set despite a clear in the same cycle");

   chk_restart_clears_valid: assert property (
      RESTART |=> !CONFIG_VALID)
      else $error("valid flag survived a restart");

   chk_restart_keeps_high: assert property (
      RESTART |=> $stable(id_high_reg))
      else $error("identifier high register changed on restart");

   chk_reserved_held_zero: assert property (
      id_low_reg[wake_filter_pkg::POS_RESERVED] == 1'b0)
      else $error("reserved bit stored as one");

   chk_upper_id_readback: assert property (
      low_write ##1 low_read |=> REG_RDATA[15:8] == $past(REG_WDATA[15:8], 2))
      else $error("identifier bits 12..5 read back wrong");

   chk_low_id_readback: assert property (
      low_write ##1 low_read |=> REG_RDATA[6:1] == $past(REG_WDATA[6:1], 2))
      else $error("identifier bits 4..0 or remote flag read back wrong");

   chk_reset_clears_outputs: assert property (
      @(posedge REF_CLK) disable iff (1'b0)
      RST |=> (REG_RDATA == 16'h0000) && !WAKE_MATCH && (id_high_reg == 16'h0000))
      else $error("reset did not clear read data, match or high identifier");

endmodule

`default_nettype wire

// ### wake_host_model.sv
// Host microcontroller model driving the decoded register strobe port
`timescale 1ns/100ps
`default_nettype none

module wake_host_model (
   input  wire logic        clk,
   output logic             wr,
   output logic             rd,
   output logic [6:0]       addr,
   output logic [15:0]      wdata
);
   initial begin
      wr = 1'b0;
      rd = 1'b0;
      addr = 7'h00;
      wdata = 16'h0000;
   end

   // ======================================================
   // One access, held across exactly one rising edge
   task access(input logic w, input logic [6:0] a, input logic [15:0] d);
      @(negedge clk);
      wr = w;
      rd = !w;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
      // Idle bus shows stale-inverted values so nothing leans on them
      addr = ~a;
      wdata = ~d;
   endtask

   // Software validates the setup and then arms the filter
   task set_valid();
      access(1'b1, wake_filter_pkg::OFFS_CTRL, 16'h0001);
   endtask
endmodule

`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the wake-up frame identifier filter registers
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   logic        REF_CLK = 1'b0;
   logic        RST, RESTART, WAKE_EVENT, OTHER_CONFIG_WRITE;
   logic        RX_FRAME_VALID, RX_REMOTE, RX_EXTENDED, REG_WR, REG_RD;
   logic        CONFIG_VALID, WAKE_MATCH, rd_q = 1'b0, fr_q = 1'b0, xr, xe;
   logic [6:0]  REG_ADDR;
   logic [15:0] REG_WDATA, REG_RDATA, rq[$], m[3];
   logic [28:0] RX_ID, xid;
   logic [12:0] lce;
   logic        mq[$];
   logic [31:0] seed = 32'h000020F2;
   logic [6:0]  ad[3] = '{wake_filter_pkg::OFFS_ID_LOW, wake_filter_pkg::OFFS_MASK_HIGH,
                          wake_filter_pkg::OFFS_ID_HIGH};
   logic [15:0] wm[3] = '{wake_filter_pkg::ID_LOW_WMASK, 16'hFFFF, 16'hFFFF};
   int          num_errors = 0, checked = 0;

   always #12.5 REF_CLK = ~REF_CLK;

   wake_host_model u_wake_host_model (.clk(REF_CLK), .wr(REG_WR), .rd(REG_RD), .addr(REG_ADDR),
                                      .wdata(REG_WDATA));
   wake_frame_id_filter_regs u_wake_frame_id_filter_regs (.REF_CLK(REF_CLK), .RST(RST),
      .RESTART(RESTART), .WAKE_EVENT(WAKE_EVENT), .OTHER_CONFIG_WRITE(OTHER_CONFIG_WRITE),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .RX_FRAME_VALID(RX_FRAME_VALID), .RX_ID(RX_ID), .RX_REMOTE(RX_REMOTE),
      .RX_EXTENDED(RX_EXTENDED), .LOW_COMPARE_ENABLE(lce), .CONFIG_VALID(CONFIG_VALID),
      .WAKE_MATCH(WAKE_MATCH));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ======================================================
   // Monitor: answers land on the taking edge and are checked half a cycle later
   always @(posedge REF_CLK) begin
      rd_q <= REG_RD;
      fr_q <= RX_FRAME_VALID;
   end
   always @(negedge REF_CLK) begin
      if (rd_q) check("read data", REG_RDATA, rq.size() ? rq.pop_front() : 16'hXXXX);
      if (fr_q) check("wake match", {15'h0, WAKE_MATCH},
                      mq.size() ? {15'h0, mq.pop_front()} : 16'hXXXX);
   end

   task rd(input logic [6:0] a, input logic [15:0] e);
      rq.push_back(e);
      u_wake_host_model.access(1'b0, a, 16'h0000);
   endtask

   // Expected hit from mirrored registers; enable one means compare
   // Flag state v is what the scenario has set up, not what the design shows
   task frame(input logic [28:0] id, input logic r, input logic e, input logic v);
      logic [28:0] want;
      want = {m[2], m[0][15:8], m[0][6:2]};
      mq.push_back(v && (((id ^ want) & {m[1], lce}) == 29'h0) && r == m[0][1] && e == m[0][0]);
      @(negedge REF_CLK);
      {RX_FRAME_VALID, RX_ID, RX_REMOTE, RX_EXTENDED} = {1'b1, id, r, e};
      @(negedge REF_CLK);
      {RX_FRAME_VALID, RX_ID} = {1'b0, ~id};
   endtask

   initial begin
      repeat (6000) @(posedge REF_CLK);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      {RESTART, WAKE_EVENT, OTHER_CONFIG_WRITE, RX_FRAME_VALID, RX_REMOTE, RX_EXTENDED} = 6'h00;
      RST = 1'b1;
      RX_ID = 29'h0;
      lce = 13'(rnd());
      repeat (4) @(negedge REF_CLK);
      RST = 1'b0;
      for (int i = 0; i < 3; i++) rd(ad[i], 16'h0000);
      rd(7'h40, 16'h0000);
      $display("reset values done");
      u_wake_host_model.access(1'b1, ad[0], 16'hFFFF);
      rd(ad[0], 16'hFF7F);
      for (int k = 0; k < 4; k++) for (int i = 0; i < 3; i++) begin
         m[i] = 16'(rnd()) & wm[i];
         // Only the reserved bit of the low register is forced high
         u_wake_host_model.access(1'b1, ad[i], m[i] | ~wm[i]);
         rd(ad[i], m[i]);
      end
      $display("field layout done");
      u_wake_host_model.set_valid();
      check("valid set", {15'h0, CONFIG_VALID}, 16'h0001);
      rd(wake_filter_pkg::OFFS_CTRL, 16'h0001);
      for (int k = 0; k < 40; k++) begin
         xid = {m[2], m[0][15:8], m[0][6:2]};
         seed = rnd();
         if (seed[0]) xid ^= 29'h1 << (seed[9:4] % 29);
         xr = m[0][1] ^ (seed[1] & seed[2]);
         xe = m[0][0] ^ (seed[3] & seed[2]);
         frame(xid, xr, xe, 1'b1);
      end
      // All enables off: any identifier with agreeing flags must hit
      lce = 13'h0000;
      m[1] = 16'h0000;
      u_wake_host_model.access(1'b1, ad[1], m[1]);
      u_wake_host_model.set_valid();
      frame(29'(rnd()), m[0][1], m[0][0], 1'b1);
      $display("matching done");
      for (int k = 0; k < 3; k++) begin
         u_wake_host_model.set_valid();
         if (k == 0) u_wake_host_model.access(1'b1, ad[1], m[1]);
         else begin
            @(negedge REF_CLK);
            {WAKE_EVENT, OTHER_CONFIG_WRITE} = k[1:0];
            @(negedge REF_CLK);
            {WAKE_EVENT, OTHER_CONFIG_WRITE} = 2'b00;
         end
         check("valid cleared", {15'h0, CONFIG_VALID}, 16'h0000);
      end
      @(negedge REF_CLK);
      OTHER_CONFIG_WRITE = 1'b1;
      u_wake_host_model.set_valid();
      OTHER_CONFIG_WRITE = 1'b0;
      check("clear beats set", {15'h0, CONFIG_VALID}, 16'h0000);
      frame({m[2], m[0][15:8], m[0][6:2]}, m[0][1], m[0][0], 1'b0);
      $display("valid flag done");
      u_wake_host_model.set_valid();
      @(negedge REF_CLK);
      RESTART = 1'b1;
      u_wake_host_model.access(1'b1, ad[0], ~m[0]);
      u_wake_host_model.access(1'b1, ad[1], ~m[1]);
      rd(ad[0], m[0]);
      rd(ad[1], m[1]);
      RESTART = 1'b0;
      check("restart valid", {15'h0, CONFIG_VALID}, 16'h0000);
      @(negedge REF_CLK);
      RST = 1'b1;
      @(negedge REF_CLK);
      RST = 1'b0;
      for (int i = 0; i < 3; i++) rd(ad[i], 16'h0000);
      $display("restart and reset done");
      repeat (2) @(negedge REF_CLK);
      tally_and_finish();
   end
endmodule

`default_nettype wire
